/* File: src/timer_ctrl_top.sv */
// Channel-8 prescale select and channel-9 edge and capture-trigger control registers
`timescale 1ns/100ps

module timer_ctrl_top
#(
    parameter int CNT_W = 16
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input timer_ctrl_pkg::reg_req_t bus_req,
    output logic [timer_ctrl_pkg::DATA_W-1:0] rdata,
    // Count enables for the two down-counter groups
    output logic low_group_tick,
    output logic high_group_tick,
    // Event inputs, compare values and counts
    input wire logic [timer_ctrl_pkg::EV_CHANNELS-1:0] event_in,
    input wire logic [timer_ctrl_pkg::EV_CHANNELS-1:0][CNT_W-1:0] event_compare_value,
    output logic [timer_ctrl_pkg::EV_CHANNELS-1:0][CNT_W-1:0] event_counter,
    // Capture request towards channel 3
    output logic capture_trigger
);
    import timer_ctrl_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] clk_sel;
        logic [DATA_W-1:0] edge_ab;
        logic [DATA_W-1:0] edge_cd;
        logic [DATA_W-1:0] edge_ef;
        logic [DATA_W-1:0] rdata;
        logic low_tick;
        logic high_tick;
        logic capture;
    } top_state_t;

    top_state_t st;
    top_state_t next_st;

    logic [PRE_TAPS-1:0] pre_tick;
    prescale_t low_sel;
    prescale_t high_sel;
    logic [EV_CHANNELS-1:0][1:0] edge_sel;
    logic [TRIG_CHANNELS-1:0] trig_en;
    logic [EV_CHANNELS-1:0] match;
    logic [DATA_W-1:0] read_mux;

    // Shared divider for both down-counter groups
    prescaler u_pre
    (
        .mclk(mclk),
        .rst(rst),
        .tick(pre_tick)
    );

    // Field extraction from the stored registers
    assign low_sel = prescale_t'(st.clk_sel[PRE_LO_LSB +: 3]);
    assign high_sel = prescale_t'(st.clk_sel[PRE_HI_LSB +: 3]);

    // Channel order A..F: low then high field of each register
    assign edge_sel = {
        st.edge_ef[EDGE_HI_LSB +: 2],
        st.edge_ef[EDGE_LO_LSB +: 2],
        st.edge_cd[EDGE_HI_LSB +: 2],
        st.edge_cd[EDGE_LO_LSB +: 2],
        st.edge_ab[EDGE_HI_LSB +: 2],
        st.edge_ab[EDGE_LO_LSB +: 2]
    };

    // Trigger enables for A, B, C, D
    assign trig_en = {
        st.edge_cd[TRIG_HI_BIT],
        st.edge_cd[TRIG_LO_BIT],
        st.edge_ab[TRIG_HI_BIT],
        st.edge_ab[TRIG_LO_BIT]
    };

    // One event counter per channel
    for (genvar i = 0; i < EV_CHANNELS; i++)
    begin : g_ev
        event_channel #(.CNT_W(CNT_W)) u_ch
        (
            .mclk(mclk),
            .rst(rst),
            .event_in(event_in[i]),
            .edge_pick(edge_mode_t'(edge_sel[i])),
            .compare(event_compare_value[i]),
            .count(event_counter[i]),
            .match(match[i])
        );
    end

    // Read view; reserved bits are never stored so they read as zero
    always_comb
    begin
        case (bus_req.addr)
            OFS_DOWN_COUNTER_CLOCK_SELECT: read_mux = st.clk_sel;
            OFS_EVENT_EDGE_TRIGGER_AB: read_mux = st.edge_ab;
            OFS_EVENT_EDGE_TRIGGER_CD: read_mux = st.edge_cd;
            OFS_EVENT_EDGE_EF: read_mux = st.edge_ef;
            default: read_mux = '0; // Unmapped offsets read zero
        endcase
    end

    // Next state: register writes, read return, tick select, capture request
    always_comb
    begin
        next_st = st;
        if (bus_req.wr)
        begin
            case (bus_req.addr)
                OFS_DOWN_COUNTER_CLOCK_SELECT:
                    next_st.clk_sel = bus_req.wdata & MASK_CLOCK_SELECT;
                OFS_EVENT_EDGE_TRIGGER_AB:
                    next_st.edge_ab = bus_req.wdata & MASK_EDGE_TRIGGER;
                OFS_EVENT_EDGE_TRIGGER_CD:
                    next_st.edge_cd = bus_req.wdata & MASK_EDGE_TRIGGER;
                OFS_EVENT_EDGE_EF:
                    next_st.edge_ef = bus_req.wdata & MASK_EDGE_ONLY;
                default:
                    next_st.rdata = st.rdata; // Writes to unmapped offsets are dropped
            endcase
        end
        // Read data stands only in the cycle after the strobe
        next_st.rdata = bus_req.rd ? read_mux : '0;
        // Prohibited codes give no tick rather than an arbitrary rate
        next_st.low_tick = (low_sel <= PRE_DIV32) ? pre_tick[low_sel] : 1'b0;
        next_st.high_tick = (high_sel <= PRE_DIV32) ? pre_tick[high_sel] : 1'b0;
        // Any enabled match among A..D requests one capture
        next_st.capture = |(match[TRIG_CHANNELS-1:0] & trig_en);
    end

    // All control state clears to zero, trigger enables included
    always_ff @(posedge mclk)
    begin
        if (rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign rdata = st.rdata;
    assign low_group_tick = st.low_tick;
    assign high_group_tick = st.high_tick;
    assign capture_trigger = st.capture;

    // Reserved bit positions never read back as one
    property p_reserved_zero;
        @(posedge mclk) disable iff (rst)
        !rdata[RSVD_HI_BIT] && !rdata[RSVD_LO_BIT];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bit read as one");

    // Write then read of the AB register returns the writable bits
    sequence s_write_ab;
        bus_req.wr && bus_req.addr == OFS_EVENT_EDGE_TRIGGER_AB;
    endsequence

    sequence s_read_ab;
        bus_req.rd && !bus_req.wr && bus_req.addr == OFS_EVENT_EDGE_TRIGGER_AB;
    endsequence

    property p_write_read_ab;
        @(posedge mclk) disable iff (rst)
        s_write_ab ##1 s_read_ab
        |=> rdata == ($past(bus_req.wdata, 2) & MASK_EDGE_TRIGGER);
    endproperty
    a_write_read_ab: assert property (p_write_read_ab)
        else $error("edge register read does not match last write");

    // Undivided code gives a tick every cycle
    property p_div1_low;
        @(posedge mclk) disable iff (rst)
        (low_sel == PRE_DIV1)[*2] |-> low_group_tick;
    endproperty
    a_div1_low: assert property (p_div1_low)
        else $error("low group missing tick at undivided rate");

    // Divide-by-two code: a tick is followed by a gap of one cycle
    sequence s_div2_tick;
        (high_sel == PRE_DIV2)[*3] ##0 high_group_tick;
    endsequence

    property p_div2_high;
        @(posedge mclk) disable iff (rst)
        s_div2_tick |=> !high_group_tick ##1
            (high_group_tick || $past(high_sel) != PRE_DIV2);
    endproperty
    a_div2_high: assert property (p_div2_high)
        else $error("high group tick spacing wrong at divide by two");

    // Prohibited codes never produce a tick
    property p_bad_code;
        @(posedge mclk) disable iff (rst)
        low_group_tick |-> $past(low_sel) <= PRE_DIV32;
    endproperty
    a_bad_code: assert property (p_bad_code)
        else $error("tick issued for prohibited prescale code");

    // Enabled B match requests capture on the next cycle
    property p_trig_b;
        @(posedge mclk) disable iff (rst)
        match[1] && trig_en[1] |=> capture_trigger;
    endproperty
    a_trig_b: assert property (p_trig_b)
        else $error("B match with enable gave no capture request");

    // Enabled A match requests capture on the next cycle
    property p_trig_a;
        @(posedge mclk) disable iff (rst)
        match[0] && trig_en[0] |=> capture_trigger;
    endproperty
    a_trig_a: assert property (p_trig_a)
        else $error("A match with enable gave no capture request");

    // A capture request always has an enabled match behind it
    property p_trig_cause;
        @(posedge mclk) disable iff (rst)
        capture_trigger |-> $past(|(match[TRIG_CHANNELS-1:0] & trig_en));
    endproperty
    a_trig_cause: assert property (p_trig_cause)
        else $error("capture request without an enabled match");

    // Reset leaves every enable clear and no request pending
    property p_reset_clear;
        @(posedge mclk)
        rst |=> trig_en == '0 && !capture_trigger && st.clk_sel == RST_REG;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("control state not cleared by reset");

    // Read data stands one cycle only
    property p_rdata_one;
        @(posedge mclk) disable iff (rst)
        !bus_req.rd |=> rdata == '0;
    endproperty
    a_rdata_one: assert property (p_rdata_one)
        else $error("read data present without a read strobe");

    // Write then read of the CD register returns the writable bits
    sequence s_write_cd;
        bus_req.wr && bus_req.addr == OFS_EVENT_EDGE_TRIGGER_CD;
    endsequence

    sequence s_read_cd;
        bus_req.rd && !bus_req.wr && bus_req.addr == OFS_EVENT_EDGE_TRIGGER_CD;
    endsequence

    property p_write_read_cd;
        @(posedge mclk) disable iff (rst)
        s_write_cd ##1 s_read_cd
        |=> rdata == ($past(bus_req.wdata, 2) & MASK_EDGE_TRIGGER);
    endproperty
    a_write_read_cd: assert property (p_write_read_cd)
        else $error("trigger register read does not match last write");

    // Write then read of the EF register; it has no trigger enables to keep
    sequence s_write_ef;
        bus_req.wr && bus_req.addr == OFS_EVENT_EDGE_EF;
    endsequence

    sequence s_read_ef;
        bus_req.rd && !bus_req.wr && bus_req.addr == OFS_EVENT_EDGE_EF;
    endsequence

    property p_write_read_ef;
        @(posedge mclk) disable iff (rst)
        s_write_ef ##1 s_read_ef
        |=> rdata == ($past(bus_req.wdata, 2) & MASK_EDGE_ONLY);
    endproperty
    a_write_read_ef: assert property (p_write_read_ef)
        else $error("edge-only register read does not match last write");

    // Write then read of the clock select register returns both fields
    sequence s_write_sel;
        bus_req.wr && bus_req.addr == OFS_DOWN_COUNTER_CLOCK_SELECT;
    endsequence

    sequence s_read_sel;
        bus_req.rd && !bus_req.wr && bus_req.addr == OFS_DOWN_COUNTER_CLOCK_SELECT;
    endsequence

    property p_write_read_sel;
        @(posedge mclk) disable iff (rst)
        s_write_sel ##1 s_read_sel
        |=> rdata == ($past(bus_req.wdata, 2) & MASK_CLOCK_SELECT);
    endproperty
    a_write_read_sel: assert property (p_write_read_sel)
        else $error("clock select read does not match last write");

    // Undivided code on the high group also ticks every cycle
    property p_div1_high;
        @(posedge mclk) disable iff (rst)
        (high_sel == PRE_DIV1)[*2] |-> high_group_tick;
    endproperty
    a_div1_high: assert property (p_div1_high)
        else $error("high group missing tick at undivided rate");

    // Enabled C match requests capture on the next cycle
    property p_trig_c;
        @(posedge mclk) disable iff (rst)
        match[2] && trig_en[2] |=> capture_trigger;
    endproperty
    a_trig_c: assert property (p_trig_c)
        else $error("C match with enable gave no capture request");

    // Enabled D match requests capture on the next cycle
    property p_trig_d;
        @(posedge mclk) disable iff (rst)
        match[3] && trig_en[3] |=> capture_trigger;
    endproperty
    a_trig_d: assert property (p_trig_d)
        else $error("D match with enable gave no capture request");

    // With every enable clear a match must not reach channel 3
    property p_trig_off;
        @(posedge mclk) disable iff (rst)
        trig_en == '0 |=> !capture_trigger;
    endproperty
    a_trig_off: assert property (p_trig_off)
        else $error("capture request while all trigger enables are clear");

    // Reset also silences the read port and both tick outputs
    property p_reset_outputs;
        @(posedge mclk)
        rst |=> rdata == '0 && !low_group_tick && !high_group_tick;
    endproperty
    a_reset_outputs: assert property (p_reset_outputs)
        else $error("outputs not quiet after reset");

endmodule

/* File: src/timer_ctrl_pkg.sv */
// Shared constants and types for the timer prescale and event-edge control block
package timer_ctrl_pkg;

    // Register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // Register offsets (byte index on the register port)
    localparam logic [ADDR_W-1:0] OFS_DOWN_COUNTER_CLOCK_SELECT = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_EVENT_EDGE_TRIGGER_AB = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_EVENT_EDGE_TRIGGER_CD = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_EVENT_EDGE_EF = 4'h3;

    // Values after reset
    localparam logic [DATA_W-1:0] RST_REG = 8'h00;

    // Writable bit masks; reserved bits are never stored
    localparam logic [DATA_W-1:0] MASK_CLOCK_SELECT = 8'h77;
    localparam logic [DATA_W-1:0] MASK_EDGE_TRIGGER = 8'h77;
    localparam logic [DATA_W-1:0] MASK_EDGE_ONLY = 8'h33;

    // Field positions
    localparam int PRE_LO_LSB = 0;
    localparam int PRE_HI_LSB = 4;
    localparam int EDGE_LO_LSB = 0;
    localparam int EDGE_HI_LSB = 4;
    localparam int TRIG_LO_BIT = 2;
    localparam int TRIG_HI_BIT = 6;
    localparam int RSVD_HI_BIT = 7;
    localparam int RSVD_LO_BIT = 3;

    // Channel counts
    localparam int EV_CHANNELS = 6;
    localparam int TRIG_CHANNELS = 4;
    localparam int PRE_STAGES = 5;
    localparam int PRE_TAPS = 6;
    localparam int SYNC_STAGES = 3;

    // Prescale codes: base clock divided by 1 to 32
    typedef enum logic [2:0] {
        PRE_DIV1 = 3'b000,
        PRE_DIV2 = 3'b001,
        PRE_DIV4 = 3'b010,
        PRE_DIV8 = 3'b011,
        PRE_DIV16 = 3'b100,
        PRE_DIV32 = 3'b101,
        PRE_BAD6 = 3'b110,
        PRE_BAD7 = 3'b111
    } prescale_t;

    // Edge selection codes for the event counters
    typedef enum logic [1:0] {
        EDGE_OFF = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_BOTH = 2'b11
    } edge_mode_t;

    // One register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

endpackage

/* File: src/prescaler.sv */
// Free-running divider giving one-cycle ticks at the base rate divided by powers of two
`timescale 1ns/100ps

module prescaler
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Tick k pulses once every 2**k cycles
    output logic [timer_ctrl_pkg::PRE_TAPS-1:0] tick
);
    import timer_ctrl_pkg::*;

    typedef struct packed {
        logic [PRE_STAGES-1:0] cnt;
    } pre_state_t;

    pre_state_t st;
    pre_state_t next_st;

    // Counter advances every cycle
    always_comb
    begin
        next_st = st;
        next_st.cnt = st.cnt + 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            st <= '0;
        else
            st <= next_st;
    end

    // Tap k fires when the low k bits are all ones; tap 0 is the undivided rate
    assign tick[0] = 1'b1;
    for (genvar k = 1; k < PRE_TAPS; k++)
    begin : g_tap
        assign tick[k] = &st.cnt[k-1:0];
    end

endmodule

/* File: src/event_channel.sv */
// One event counter: synchronised input, selectable edge, compare match pulse
`timescale 1ns/100ps

module event_channel
#(
    parameter int CNT_W = 16
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Event pin and edge choice
    input wire logic event_in,
    input timer_ctrl_pkg::edge_mode_t edge_pick,
    // Compare value and results
    input wire logic [CNT_W-1:0] compare,
    output logic [CNT_W-1:0] count,
    output logic match
);
    import timer_ctrl_pkg::*;

    typedef struct packed {
        logic [SYNC_STAGES-1:0] sync;
        logic lvl;
        logic [CNT_W-1:0] cnt;
        logic match;
    } ch_state_t;

    ch_state_t st;
    ch_state_t next_st;
    logic agree;
    logic rise;
    logic fall;
    logic inc;
    logic [CNT_W-1:0] cnt_plus;

    // Only stages 1 and 2 are inspected; stage 0 may be metastable
    assign agree = st.sync[1] == st.sync[2];
    assign rise = agree && st.sync[2] && !st.lvl;
    assign fall = agree && !st.sync[2] && st.lvl;
    assign cnt_plus = st.cnt + 1'b1;

    // Edge qualification per selected mode
    always_comb
    begin
        case (edge_pick)
            EDGE_OFF: inc = 1'b0;
            EDGE_RISE: inc = rise;
            EDGE_FALL: inc = fall;
            EDGE_BOTH: inc = rise || fall;
            default: inc = 1'b0;
        endcase
    end

    // Next state: shift sync chain, track level, count and flag equality
    always_comb
    begin
        next_st = st;
        next_st.sync = {st.sync[1:0], event_in};
        if (agree)
            next_st.lvl = st.sync[2];
        next_st.match = 1'b0;
        if (inc)
        begin
            next_st.cnt = cnt_plus;
            next_st.match = cnt_plus == compare;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign count = st.cnt;
    assign match = st.match;

    // A qualified edge advances the counter by exactly one
    property p_count_step;
        @(posedge mclk) disable iff (rst)
        inc |=> count == $past(count) + 1'b1;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("event counter did not advance on a qualified edge");

    // Disabled channel holds its count
    property p_count_off;
        @(posedge mclk) disable iff (rst)
        edge_pick == EDGE_OFF |=> $stable(count);
    endproperty
    a_count_off: assert property (p_count_off)
        else $error("event counter moved while counting disabled");

endmodule

/* File: testbench/event_partner.sv */
// Far-side model: event pin driver with tick and capture pulse counters
`timescale 1ns/100ps

module event_partner
(
    // Clock
    input wire logic mclk,
    // Pulses from the block
    input wire logic low_group_tick,
    input wire logic high_group_tick,
    input wire logic capture_trigger,
    // Event pins towards the block
    output logic [timer_ctrl_pkg::EV_CHANNELS-1:0] event_in
);
    import timer_ctrl_pkg::*;

    int low_ticks = 0;
    int high_ticks = 0;
    int captures = 0;

    initial event_in = '0;

    // Count every sampled cycle in which a pulse is high; unknowns never count
    always @(posedge mclk)
    begin
        low_ticks += int'(low_group_tick === 1'b1);
        high_ticks += int'(high_group_tick === 1'b1);
        captures += int'(capture_trigger === 1'b1);
    end

    // Flip one pin, then hold it; under two cycles an edge may be lost
    task automatic flip(input int ch, input int hold);
        @(posedge mclk);
        event_in[ch] <= ~event_in[ch];
        repeat (hold) @(posedge mclk);
    endtask
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench for the prescale select and event-edge control block
`timescale 1ns/100ps

module testbench;
    import timer_ctrl_pkg::*;

    logic mclk = 1'b0;
    logic rst = 1'b1;
    reg_req_t bus_req = '0;
    logic [DATA_W-1:0] rdata;
    logic low_group_tick;
    logic high_group_tick;
    logic [EV_CHANNELS-1:0] event_in;
    logic [EV_CHANNELS-1:0][15:0] cmp_q = '1;
    logic [EV_CHANNELS-1:0][15:0] event_counter;
    logic capture_trigger;
    logic [15:0] exp_cnt [EV_CHANNELS];
    int miscompares = 0;
    int checks_done = 0;

    // 50 MHz clock
    always #10 mclk = ~mclk;

    timer_ctrl_top #(.CNT_W(16)) u_timer_ctrl_top
    (
        .mclk(mclk),
        .rst(rst),
        .bus_req(bus_req),
        .rdata(rdata),
        .low_group_tick(low_group_tick),
        .high_group_tick(high_group_tick),
        .event_in(event_in),
        .event_compare_value(cmp_q),
        .event_counter(event_counter),
        .capture_trigger(capture_trigger)
    );

    event_partner u_event_partner
    (
        .mclk(mclk),
        .low_group_tick(low_group_tick),
        .high_group_tick(high_group_tick),
        .capture_trigger(capture_trigger),
        .event_in(event_in)
    );

    // Compare a design value; case inequality so unknowns fail
    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t value got %h expected %h", $time, got, exp);
        end
    endtask

    // Compare a pulse count gathered by the partner
    task automatic cmp_num(input int got, input int exp);
        checks_done++;
        if (got != exp)
        begin
            miscompares++;
            $display("[FAIL] %0t pulse count got %0d expected %0d", $time, got, exp);
        end
    endtask

    // One-cycle write strobe
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        bus_req <= '0;
    endtask

    // Read strobe; data is looked at only in the cycle after the read edge
    task automatic rd_cmp(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge mclk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge mclk);
        bus_req <= '0;
        #1;
        cmp_val(16'(rdata), 16'(exp));
    endtask

    // Write strobe followed at once by a read strobe of the same offset
    task automatic wr_rd_cmp(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
        input logic [DATA_W-1:0] exp);
        @(posedge mclk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge mclk);
        bus_req <= '0;
        #1;
        cmp_val(16'(rdata), 16'(exp));
    endtask

    // Edge mode and capture enable of one event channel; the pair's other field is zeroed
    task automatic chan_cfg(input int c, input int m, input int en);
        wr_reg(4'(1 + c / 2), 8'((m | (en << 2)) << ((c % 2) * 4)));
    endtask

    // Rising then falling edge, then enough cycles for the synchroniser
    task automatic pulse_pair(input int c, input int hold);
        u_event_partner.flip(c, hold);
        u_event_partner.flip(c, hold);
        repeat (5) @(posedge mclk);
        #1;
    endtask

    task automatic check_counts;
        for (int j = 0; j < EV_CHANNELS; j++)
            cmp_val(event_counter[j], exp_cnt[j]);
    endtask

    task automatic tally_and_finish;
        $display("checks_done %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Watchdog, about ten times the expected run
    initial
    begin
        #300000;
        miscompares++;
        tally_and_finish();
    end

    // Main sequence
    initial
    begin
        int c0;
        int l0;
        int h0;
        for (int j = 0; j < EV_CHANNELS; j++)
            exp_cnt[j] = 16'h0000;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        // Reset values, offsets 4 and 5 unmapped
        for (int a = 0; a < 6; a++)
            rd_cmp(4'(a), RST_REG);
        // Legal writes with reserved bits zero, one write to an unmapped offset
        wr_reg(OFS_DOWN_COUNTER_CLOCK_SELECT, 8'h77);
        wr_reg(OFS_EVENT_EDGE_TRIGGER_AB, 8'h77);
        wr_reg(OFS_EVENT_EDGE_TRIGGER_CD, 8'h77);
        wr_reg(OFS_EVENT_EDGE_EF, 8'h33);
        wr_reg(4'h9, 8'h55);
        rd_cmp(OFS_DOWN_COUNTER_CLOCK_SELECT, 8'h77);
        rd_cmp(OFS_EVENT_EDGE_TRIGGER_AB, 8'h77);
        rd_cmp(OFS_EVENT_EDGE_TRIGGER_CD, 8'h77);
        rd_cmp(OFS_EVENT_EDGE_EF, 8'h33);
        rd_cmp(4'h9, 8'h00);
        @(posedge mclk);
        #1;
        cmp_val(16'(rdata), 16'h0000);
        // Write and read back to back on every register; pins stay idle here
        wr_rd_cmp(OFS_DOWN_COUNTER_CLOCK_SELECT, 8'h25, 8'h25);
        wr_rd_cmp(OFS_EVENT_EDGE_TRIGGER_AB, 8'h46, 8'h46);
        wr_rd_cmp(OFS_EVENT_EDGE_TRIGGER_CD, 8'h61, 8'h61);
        wr_rd_cmp(OFS_EVENT_EDGE_EF, 8'h12, 8'h12);
        // Both groups at once, opposite codes; codes six and seven are never written
        for (int k = 0; k < 6; k++)
        begin
            wr_reg(OFS_DOWN_COUNTER_CLOCK_SELECT, {1'b0, 3'(5 - k), 1'b0, 3'(k)});
            repeat (4) @(posedge mclk);
            #1;
            l0 = u_event_partner.low_ticks;
            h0 = u_event_partner.high_ticks;
            repeat (64) @(posedge mclk);
            #1;
            cmp_num(u_event_partner.low_ticks - l0, 64 >> k);
            cmp_num(u_event_partner.high_ticks - h0, 64 >> (5 - k));
        end
        // Every edge mode on every channel, prompt and slow pin holds
        c0 = u_event_partner.captures;
        for (int c = 0; c < EV_CHANNELS; c++)
            for (int m = 0; m < 4; m++)
            begin
                chan_cfg(c, m, 0);
                pulse_pair(c, 2 + (c % 3) * 3);
                if (m != 0)
                    exp_cnt[c] += (m == 3) ? 16'h0002 : 16'h0001;
                check_counts();
            end
        cmp_num(u_event_partner.captures - c0, 0);
        // Counter steps onto its compare value, trigger off then on
        for (int c = 0; c < 4; c++)
            for (int en = 0; en < 2; en++)
            begin
                @(posedge mclk);
                cmp_q[c] <= exp_cnt[c] + 16'h0001;
                chan_cfg(c, 1, en);
                c0 = u_event_partner.captures;
                pulse_pair(c, 6);
                exp_cnt[c] += 16'h0001;
                cmp_num(u_event_partner.captures - c0, en);
                check_counts();
            end
        // Second reset in mid-run clears registers and counters
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        #1;
        for (int j = 0; j < EV_CHANNELS; j++)
            exp_cnt[j] = 16'h0000;
        check_counts();
        for (int a = 0; a < 4; a++)
            rd_cmp(4'(a), RST_REG);
        tally_and_finish();
    end
endmodule
